//--- rtl/rrl_leader_det.sv
`timescale 1ns/1ps
module rrl_leader_det (
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   input  wire logic                    samp_tick,
   input  wire logic                    rx_in,
   input  wire logic                    rx_en,
   input  wire logic                    leader_en,
   input  wire logic [7:0]              data_th,
   input  wire rrl_pkg::rrl_leader_cfg_t cfg,
   output rrl_pkg::rrl_rx_evt_t         evt
);
   typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} rrl_det_st_t;

   rrl_det_st_t                  st_q;
   logic [rrl_pkg::CNT_W-1:0]    low_q;
   logic [rrl_pkg::CNT_W-1:0]    cyc_q;
   logic                         rx_q;
   logic                         fall;
   rrl_pkg::rrl_leader_mode_t    mode;

   // Limit in sampling clocks: field times four
   function automatic logic [rrl_pkg::CNT_W-1:0] lim(input logic [7:0] f);
      lim = {{(rrl_pkg::CNT_W-10){1'b0}}, f, 2'b00};
   endfunction

   always_comb begin
      if (!leader_en || cfg.lcmax == 8'h00) begin
         mode = rrl_pkg::RRL_LD_NONE;
      end else if (cfg.llmax == 8'h00) begin
         mode = rrl_pkg::RRL_LD_HIGH_ONLY;
      end else begin
         mode = rrl_pkg::RRL_LD_LOW_HIGH;
      end
   end

   assign fall = samp_tick && rx_q && !rx_in;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_q <= 1'b1;
      end else if (samp_tick) begin
         rx_q <= rx_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !rx_en) begin
         st_q  <= S_IDLE;
         low_q <= '0;
         cyc_q <= '0;
      end else if (samp_tick) begin
         case (st_q)
            S_IDLE: begin
               if (fall) begin
                  st_q  <= S_LOW;
                  low_q <= 12'h001;
                  cyc_q <= 12'h001;
               end
            end
            S_LOW: begin
               if (rx_in) begin
                  st_q <= S_HIGH;
               end else if (low_q != 12'hFFF) begin
                  low_q <= low_q + 12'h001;
               end
               if (cyc_q != 12'hFFF) begin
                  cyc_q <= cyc_q + 12'h001;
               end
            end
            S_HIGH: begin
               if (fall) begin
                  low_q <= 12'h001;
                  cyc_q <= 12'h001;
                  st_q  <= S_LOW;
               end else if (cyc_q != 12'hFFF) begin
                  cyc_q <= cyc_q + 12'h001;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // A cycle ends at the next falling edge; classify it then
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         evt <= '0;
      end else begin
         evt <= '0;
         if (rx_en && fall && st_q == S_HIGH) begin
            if (mode != rrl_pkg::RRL_LD_NONE
                && cyc_q >= lim(cfg.lcmin)
                && cyc_q <= lim(cfg.lcmax)
                && (mode == rrl_pkg::RRL_LD_HIGH_ONLY
                    || (low_q >= lim(cfg.llmin)
                        && low_q <= lim(cfg.llmax)))) begin
               evt.leader_det <= 1'b1;
            end else begin
               // Every cycle that is not a leader is data, whatever its low length
               evt.bit_valid <= 1'b1;
               evt.bit_value <= (cyc_q > {4'h0, data_th});
            end
         end
      end
   end
endmodule // rrl_leader_det

//--- rtl/rrl_pkg.sv
package rrl_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFS_BUF_LOW     = 8'h00;
   localparam logic [7:0] OFS_BUF_MID     = 8'h04;
   localparam logic [7:0] OFS_BUF_TOP     = 8'h08;
   localparam logic [7:0] OFS_LEADER_CTL  = 8'h0C;
   localparam logic [7:0] OFS_RX_CTL_TWO  = 8'h10;
   localparam logic [7:0] OFS_RX_STATUS   = 8'h14;

   // Field positions
   localparam int LCMAX_LSB    = 24;
   localparam int LCMIN_LSB    = 16;
   localparam int LLMAX_LSB    = 8;
   localparam int LLMIN_LSB    = 0;
   localparam int LEADER_EN_BIT = 25;
   localparam int RX_EN_BIT     = 0;
   localparam int DATA_TH_LSB   = 8;
   localparam int SEEN_CLR_BIT  = 1;

   // Reset values
   localparam logic [31:0] LEADER_CTL_RST = 32'h0000_0000;
   localparam logic [31:0] RX_CTL_TWO_RST = 32'h0000_0000;
   localparam logic [71:0] BUF_RST        = 72'h00_0000_0000_0000_0000;

   // Timing: limits count in units of four sampling clocks
   localparam int          UNIT_SHIFT = 2;
   localparam int          BUF_BITS   = 72;
   localparam int          CNT_W      = 12;
   // Data-bit threshold default, in sampling clocks
   localparam logic [7:0]  DATA_TH_RST = 8'h10;

   typedef struct packed {
      logic [7:0] lcmax;
      logic [7:0] lcmin;
      logic [7:0] llmax;
      logic [7:0] llmin;
   } rrl_leader_cfg_t;

   typedef struct packed {
      logic       leader_det;
      logic       bit_valid;
      logic       bit_value;
   } rrl_rx_evt_t;

   typedef enum logic [1:0] {
      RRL_LD_LOW_HIGH,
      RRL_LD_HIGH_ONLY,
      RRL_LD_NONE
   } rrl_leader_mode_t;

endpackage

//--- rtl/rrl_top.sv
`timescale 1ns/1ps
module rrl_top (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        rx_in,
   input  wire logic        samp_tick,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             leader_seen
);
   rrl_pkg::rrl_leader_cfg_t cfg_q;
   logic [31:0]              ctl2_q;
   logic                     rx_en_q;
   logic [7:0]               data_th_q;
   logic [rrl_pkg::BUF_BITS-1:0] buf_q;
   logic [7:0]               nbits_q;
   logic                     wr_pend_q;
   logic [7:0]               wr_addr_q;
   logic                     rd_go;
   logic                     wr_go;
   rrl_pkg::rrl_rx_evt_t     evt;

   rrl_leader_det u_det (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .samp_tick (samp_tick),
      .rx_in     (rx_in),
      .rx_en     (rx_en_q),
      .leader_en (ctl2_q[rrl_pkg::LEADER_EN_BIT]),
      .data_th   (data_th_q),
      .cfg       (cfg_q),
      .evt       (evt)
   );

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   assign wr_go = hsel && hready && htrans[1] && hwrite;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= wr_go;
         wr_addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_q     <= rrl_pkg::LEADER_CTL_RST;
         ctl2_q    <= rrl_pkg::RX_CTL_TWO_RST;
         rx_en_q   <= 1'b0;
         data_th_q <= rrl_pkg::DATA_TH_RST;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            rrl_pkg::OFS_LEADER_CTL: cfg_q <= hwdata;
            rrl_pkg::OFS_RX_CTL_TWO: ctl2_q <= hwdata & 32'h0200_0000;
            rrl_pkg::OFS_RX_STATUS: begin
               rx_en_q   <= hwdata[rrl_pkg::RX_EN_BIT];
               data_th_q <= hwdata[rrl_pkg::DATA_TH_LSB +: 8];
            end
            default: ;
         endcase
      end
   end

   // New bits enter at bit 0 and push older ones up
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         buf_q   <= rrl_pkg::BUF_RST;
         nbits_q <= 8'h00;
      end else if (evt.leader_det) begin
         buf_q   <= rrl_pkg::BUF_RST;
         nbits_q <= 8'h00;
      end else if (evt.bit_valid) begin
         buf_q   <= {buf_q[rrl_pkg::BUF_BITS-2:0], evt.bit_value};
         nbits_q <= (nbits_q == 8'hFF) ? nbits_q : nbits_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         leader_seen <= 1'b0;
      end else if (evt.leader_det) begin
         leader_seen <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == rrl_pkg::OFS_RX_STATUS) begin
         leader_seen <= hwdata[rrl_pkg::SEEN_CLR_BIT] ? 1'b0 : leader_seen;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_go) begin
         case (haddr[7:0])
            rrl_pkg::OFS_BUF_LOW: hrdata <= buf_q[31:0];
            rrl_pkg::OFS_BUF_MID: hrdata <= buf_q[63:32];
            rrl_pkg::OFS_BUF_TOP: hrdata <= {24'h000000, buf_q[71:64]};
            rrl_pkg::OFS_LEADER_CTL: hrdata <= cfg_q;
            rrl_pkg::OFS_RX_CTL_TWO: hrdata <= ctl2_q;
            rrl_pkg::OFS_RX_STATUS:
               hrdata <= {8'h00, nbits_q, data_th_q, 6'h00, leader_seen, rx_en_q};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // rrl_top

//--- sim/rrl_assertions.sv
`timescale 1ns/1ps
module rrl_assertions (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        rx_in,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        leader_seen
);
   logic       rd_q;
   logic       wr_q;
   logic [7:0] a_q;
   // Track the data phase so read data can be tied to its address
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         a_q  <= 8'h00;
      end else if (hready) begin
         rd_q <= hsel && htrans[1] && !hwrite;
         wr_q <= hsel && htrans[1] && hwrite;
         a_q  <= haddr[7:0];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   zero_wait_a: assert property (hreadyout) else $error("hreadyout low");
   okay_resp_a: assert property (!hresp) else $error("hresp not okay");
   top_upper_zero_a: assert property (rd_q && a_q == rrl_pkg::OFS_BUF_TOP
      |-> hrdata[31:8] == 24'h0)
      else $error("top word upper bits set");
   ctl_two_mask_a: assert property (rd_q && a_q == rrl_pkg::OFS_RX_CTL_TWO
      |-> hrdata[24:0] == 25'h0 && hrdata[31:26] == 6'h0)
      else $error("control two stray bits");
   unmapped_zero_a: assert property (rd_q && a_q >= 8'h18 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite)
      |=> $stable(hrdata))
      else $error("hrdata changed without read");
   seen_sticky_a: assert property (leader_seen
      && !(wr_q && a_q == rrl_pkg::OFS_RX_STATUS && hwdata[1]) |=> leader_seen)
      else $error("leader flag dropped");
   seen_on_low_a: assert property ($rose(leader_seen) |-> !rx_in)
      else $error("leader flag rose off a low");
endmodule // rrl_assertions
bind rrl_top rrl_assertions u_rrl_assertions (.core_clk, .rst_n, .rx_in, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .leader_seen);

//--- sim/rrl_ir_model.sv
`timescale 1ns/1ps
module rrl_ir_model (
   input  wire logic core_clk,
   output logic      rx_in,
   output logic      samp_tick
);
   // Sampling enable on every second clock, so each tick is two clocks
   initial begin
      rx_in = 1'b1;
      samp_tick = 1'b0;
   end
   always @(posedge core_clk) begin
      samp_tick <= ~samp_tick;
   end
   // Low part then high part; the idle line rests high between pulses
   task pulse(input int lo, input int hi);
      rx_in <= 1'b0;
      repeat (2 * lo) @(posedge core_clk);
      rx_in <= 1'b1;
      repeat (2 * hi) @(posedge core_clk);
   endtask
endmodule // rrl_ir_model

//--- sim/rrl_top_tb.sv
`timescale 1ns/1ps
module rrl_top_tb;
   localparam logic [31:0] NORM = 32'h4020_1810;
   logic        core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic        leader_seen, rx_in, samp_tick, ex;
   logic [31:0] haddr, hwdata, hrdata, r, lf;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [71:0] exp_buf;
   int          fails, check_count, lo, hi;
   // Leader shapes: hit, short low, long cycle, short cycle, long low, high-only, none,
   // disabled, both windows at their minimum, both windows at their maximum
   logic [31:0] ctl_t [10] = '{NORM, NORM, NORM, NORM, NORM, 32'h4020_0010, 32'h0020_1810,
                               NORM, NORM, NORM};
   int          lo_t  [10] = '{80, 40, 80, 80, 100, 4, 80, 80, 64, 96};
   int          hi_t  [10] = '{80, 120, 300, 30, 60, 156, 80, 80, 64, 160};
   logic        en_t  [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic        sn_t  [10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   logic [7:0]  a_t   [3] = '{rrl_pkg::OFS_BUF_TOP, rrl_pkg::OFS_RX_CTL_TWO, 8'h20};
   logic [31:0] w_t   [3] = '{32'h0, 32'h0200_0000, 32'h0};
   assign hready = hreadyout;
   rrl_top u_rrl_top (.core_clk(core_clk), .rst_n(rst_n), .rx_in(rx_in), .samp_tick(samp_tick),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .leader_seen(leader_seen));
   rrl_ir_model u_rrl_ir_model (.core_clk(core_clk), .rx_in(rx_in), .samp_tick(samp_tick));
   always #12.5 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected leader verdict; each window is its field times four sampling ticks
   function automatic logic exp_leader(input logic [31:0] c, input logic en, input int l,
                                       input int h);
      int cyc;
      cyc = l + h;
      if (!en || c[31:24] == 8'h00) begin
         return 1'b0;
      end
      if (cyc < 4 * int'(c[23:16]) || cyc > 4 * int'(c[31:24])) begin
         return 1'b0;
      end
      if (c[15:8] == 8'h00) begin
         return 1'b1;
      end
      return l >= 4 * int'(c[7:0]) && l <= 4 * int'(c[15:8]);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Single word transfer; waits on hready in both phases
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task cfg(input logic [31:0] ctl, input logic en);
      bus(1'b1, rrl_pkg::OFS_LEADER_CTL, ctl, r);
      bus(1'b1, rrl_pkg::OFS_RX_CTL_TWO, {6'h0, en, 25'h0}, r);
      // Keeps the bit threshold at 16 ticks while clearing the leader flag
      bus(1'b1, rrl_pkg::OFS_RX_STATUS, 32'h0000_1003, r);
   endtask
   task test_done;
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      test_done();
   end
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      lf = 32'h147044DD;
      exp_buf = 72'h0;
      fails = 0;
      check_count = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, rrl_pkg::OFS_LEADER_CTL, 32'h0, r);
      chk(r, 32'h0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, a_t[i], 32'h0, r);
         chk(r, 32'h0);
         bus(1'b1, a_t[i], 32'hFFFF_FFFF, r);
         bus(1'b0, a_t[i], 32'h0, r);
         chk(r, w_t[i]);
      end
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         bus(1'b1, rrl_pkg::OFS_LEADER_CTL, lf, r);
         bus(1'b0, rrl_pkg::OFS_LEADER_CTL, 32'h0, r);
         chk(r, lf);
      end
      cfg(NORM, 1'b1);
      u_rrl_ir_model.pulse(80, 80);
      for (int i = 0; i < 72; i++) begin
         lf = lfsr(lf);
         exp_buf = {exp_buf[70:0], lf[0]};
         if (lf[0]) u_rrl_ir_model.pulse(4, 20);
         else u_rrl_ir_model.pulse(4, 6);
      end
      u_rrl_ir_model.pulse(4, 4);
      chk({31'h0, leader_seen}, 32'h1);
      bus(1'b0, rrl_pkg::OFS_BUF_LOW, 32'h0, r);
      chk(r, exp_buf[31:0]);
      bus(1'b0, rrl_pkg::OFS_BUF_MID, 32'h0, r);
      chk(r, exp_buf[63:32]);
      bus(1'b0, rrl_pkg::OFS_BUF_TOP, 32'h0, r);
      chk(r, {24'h0, exp_buf[71:64]});
      // 72 bits since the leader, threshold 16, leader flag and enable set
      bus(1'b0, rrl_pkg::OFS_RX_STATUS, 32'h0, r);
      chk(r, 32'h0048_1003);
      for (int i = 0; i < 10; i++) begin
         cfg(ctl_t[i], en_t[i]);
         u_rrl_ir_model.pulse(lo_t[i], hi_t[i]);
         u_rrl_ir_model.pulse(4, 4);
         chk({31'h0, leader_seen}, {31'h0, sn_t[i]});
      end
      // Random leader shapes straddling both windows of the normal setting
      for (int i = 0; i < 6; i++) begin
         lf = lfsr(lf);
         lo = 56 + int'(lf[5:0]);
         hi = 40 + int'(lf[12:6]);
         ex = exp_leader(NORM, 1'b1, lo, hi);
         cfg(NORM, 1'b1);
         u_rrl_ir_model.pulse(lo, hi);
         u_rrl_ir_model.pulse(4, 4);
         chk({31'h0, leader_seen}, {31'h0, ex});
      end
      test_done();
   end
endmodule // rrl_top_tb
